// file: logic/usm_pkg.sv
/*
  Package for the serial unit in SPI mode: register offsets, field positions,
  reset values and mode codes.
  Assumes a byte-wide extended register port on the system clock.
*/
package usm_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [15:0] USM_OFF_CTRL1  = 16'h1000;
  localparam logic [15:0] USM_OFF_CTRL2  = 16'h1001;
  localparam logic [15:0] USM_OFF_CTRL3  = 16'h1002;
  localparam logic [15:0] USM_OFF_STATUS = 16'h1003;
  localparam logic [15:0] USM_OFF_DIV    = 16'h1004;
  localparam logic [15:0] USM_OFF_DATA   = 16'h1005;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] USM_RST_CTRL   = 8'h00;
  localparam logic [7:0] USM_RST_STATUS = 8'h80;
  localparam logic [7:0] USM_RST_DIV    = 8'hff;
  // ==========================================================================
  // Field positions, control one
  localparam int USM_C1_MODE_HI = 7;
  localparam int USM_C1_MODE_LO = 6;
  localparam int USM_C1_PAR_HI  = 5;
  localparam int USM_C1_PAR_LO  = 4;
  localparam int USM_C1_LEN_HI  = 3;
  localparam int USM_C1_ORDER   = 2;
  localparam int USM_C1_CPHA    = 1;
  localparam int USM_C1_CPOL    = 0;
  // Control two
  localparam int USM_C2_TX_EMPTY_IRQ_ENABLE  = 7;
  localparam int USM_C2_TX_DONE_IRQ_ENABLE = 6;
  localparam int USM_C2_RX_PENDING_IRQ_ENABLE = 5;
  localparam int USM_C2_WAKIE = 4;
  localparam int USM_C2_TXON  = 3;
  localparam int USM_C2_RXON  = 2;
  localparam int USM_C2_EN    = 1;
  localparam int USM_C2_DBL   = 0;
  // Control three
  localparam int USM_C3_MASTER = 7;
  localparam int USM_C3_LOOP   = 6;
  localparam int USM_C3_GATE   = 5;
  localparam int USM_C3_SSCTL  = 4;
  localparam int USM_C3_SWAP   = 3;
  localparam int USM_C3_STOP2  = 2;
  localparam int USM_C3_TX8    = 1;
  localparam int USM_C3_RX8    = 0;
  // Status
  localparam int USM_ST_DRE  = 7;
  localparam int USM_ST_TXC  = 6;
  localparam int USM_ST_RXC  = 5;
  localparam int USM_ST_WAKE = 4;
  localparam int USM_ST_SRST = 3;
  localparam int USM_ST_DOR  = 2;
  // ==========================================================================
  // Modes and counts
  localparam logic [1:0] USM_MODE_ASYNC = 2'b00;
  localparam logic [1:0] USM_MODE_SYNC  = 2'b01;
  localparam logic [1:0] USM_MODE_SPI   = 2'b11;
  localparam logic [3:0] USM_BITS_SPI   = 4'h8;
  localparam int         USM_SYNC_STAGES = 2;
endpackage

// file: logic/usm_sync.sv
/*
  Two-stage synchroniser for a bundle of pin inputs.
  Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/10ps
module usm_sync import usm_pkg::*; #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// file: logic/usm_core.sv
/*
  Serial unit control set and SPI engine: six byte registers, master and slave
  transfers in all four clock formats, bit order, slave select, pin swap,
  loopback and double-buffered data.
  Assumes a byte register port on mclk; pins are asynchronous and are
  synchronised before use. The far side keeps slave select high between
  CPHA=0 transfers and never programs a divider below 2.
*/
`timescale 1ns/10ps
module usm_core import usm_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        stop_mode,
  output logic             irq,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        ss_n_in,
  output logic             ss_n_out,
  output logic             ss_n_oe,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  input  wire logic        txd_in,
  output logic             txd_out,
  output logic             txd_oe
);
  typedef enum logic [1:0] {USM_IDLE, USM_RUN, USM_DONE} usm_state_e;

  logic [7:0] ctrl1, ctrl2, ctrl3, divider, tx_buf, shifter, rx_buf;
  logic       tx_buffer_empty_flag, tx_done_flag, rx_pending_flag, wake, dor, rxc_9;
  logic [7:0] div_cnt;
  logic [3:0] bit_cnt;
  logic       edge_ph, sck_lvl, ss_drive, out_bit;
  logic [3:0] pin_sync;
  logic       sck_d, ss_d;
  usm_state_e state;

  // ==========================================================================
  // Pin synchronisers: sck, ss_n, rxd, txd
  // Select enters inverted so a cleared synchroniser reads as deselected
  usm_sync #(.WIDTH(4)) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({sck_in, ~ss_n_in, rxd_in, txd_in}),
    .sync_out (pin_sync)
  );

  wire       s_sck   = pin_sync[3];
  wire       s_ss_n  = ~pin_sync[2];
  wire       s_rxd   = pin_sync[1];
  wire       s_txd   = pin_sync[0];
  wire [1:0] op_mode_field     = ctrl1[USM_C1_MODE_HI:USM_C1_MODE_LO];
  wire       spi_mode          = (op_mode_field == USM_MODE_SPI);
  wire       first_bit_select  = ctrl1[USM_C1_ORDER];
  wire       cpha              = ctrl1[USM_C1_CPHA];
  wire       cpol              = ctrl1[USM_C1_CPOL];
  wire       unit_enable       = ctrl2[USM_C2_EN];
  wire       receiver_on       = ctrl2[USM_C2_RXON];
  wire       master            = ctrl3[USM_C3_MASTER];
  wire       loopback_select   = ctrl3[USM_C3_LOOP];
  wire       sck_gating_select = ctrl3[USM_C3_GATE];
  wire       slave_select_control = ctrl3[USM_C3_SSCTL];
  wire       pin_swap_select   = ctrl3[USM_C3_SWAP];
  wire       active            = unit_enable & spi_mode;

  // ==========================================================================
  // Register decode
  wire sel_c1 = (reg_addr == USM_OFF_CTRL1);
  wire sel_c2 = (reg_addr == USM_OFF_CTRL2);
  wire sel_c3 = (reg_addr == USM_OFF_CTRL3);
  wire sel_st = (reg_addr == USM_OFF_STATUS);
  wire sel_dv = (reg_addr == USM_OFF_DIV);
  wire sel_dr = (reg_addr == USM_OFF_DATA);
  wire data_wr = reg_wr & sel_dr & tx_buffer_empty_flag & active;
  wire data_rd = reg_rd & sel_dr;
  wire soft_rst = reg_wr & sel_st & reg_wdata[USM_ST_SRST];
  wire blk_rst = sys_rst | soft_rst | ~active;

  // Pin routing; loopback feeds our own output back in
  wire miso_pin = pin_swap_select ? s_txd : s_rxd;
  wire mosi_pin = pin_swap_select ? s_rxd : s_txd;
  wire data_in  = loopback_select ? out_bit
                : (master ? miso_pin : mosi_pin);

  // Slave clock edges from the sampled pin; polarity strips CPOL
  wire sck_rise  = s_sck & ~sck_d;
  wire sck_fall  = ~s_sck & sck_d;
  wire lead_edge = cpol ? sck_fall : sck_rise;
  wire trail_edge = cpol ? sck_rise : sck_fall;
  wire ss_fall   = ~s_ss_n & ss_d;
  wire slave_sel = ~s_ss_n;
  // CPHA=0 slave waits for a fresh select fall; CPHA=1 may run back to back
  wire start_ok  = ~tx_buffer_empty_flag & (master | (slave_sel & (cpha | ss_fall)));

  // Master clock: half bit period of divider plus one mclk cycles
  // Ticks run on into the closing state so the last trailing edge is made
  wire div_tick = master & (state != USM_IDLE) & (div_cnt == 8'h00);
  wire m_lead   = div_tick & ~edge_ph;
  wire m_trail  = div_tick & edge_ph;
  wire lead     = master ? m_lead : (lead_edge & slave_sel);
  wire trail    = master ? m_trail : (trail_edge & slave_sel);
  wire sample   = cpha ? trail : lead;
  wire shift    = cpha ? lead : trail;
  wire last_bit = sample & (bit_cnt == USM_BITS_SPI - 4'h1);
  wire next_out = first_bit_select ? shifter[7] : shifter[0];

  // ==========================================================================
  // Control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl1   <= USM_RST_CTRL;
      ctrl2   <= USM_RST_CTRL;
      ctrl3   <= USM_RST_CTRL;
      divider <= USM_RST_DIV;
    end else if (reg_wr) begin
      if (sel_c1) ctrl1 <= reg_wdata;
      if (sel_c2) ctrl2 <= reg_wdata;
      if (sel_c3) ctrl3 <= reg_wdata;
      if (sel_dv) divider <= reg_wdata;
    end
  end

  // ==========================================================================
  // Transfer engine; slave restarts on each select fall or after a byte
  always_ff @(posedge mclk) begin
    sck_d <= s_sck;
    ss_d  <= s_ss_n;
    if (blk_rst) begin
      state    <= USM_IDLE;
      bit_cnt  <= 4'h0;
      div_cnt  <= 8'h00;
      edge_ph  <= 1'b0;
      sck_lvl  <= 1'b0;
      shifter  <= 8'h00;
      out_bit  <= 1'b0;
      ss_drive <= 1'b1;
    end else begin
      unique case (state)
        USM_IDLE: begin
          // Loaded buffer enters the shifter; first bit presented at once
          if (start_ok) begin
            shifter  <= tx_buf;
            out_bit  <= first_bit_select ? tx_buf[7] : tx_buf[0];
            state    <= USM_RUN;
            bit_cnt  <= 4'h0;
            div_cnt  <= divider;
            edge_ph  <= 1'b0;
            ss_drive <= 1'b0;
          end
        end
        USM_RUN: begin
          div_cnt <= (div_cnt == 8'h00) ? divider : div_cnt - 8'h01;
          if (div_tick) begin
            edge_ph <= ~edge_ph;
            sck_lvl <= ~sck_lvl;
          end
          if (sample) begin
            shifter <= first_bit_select ? {shifter[6:0], data_in}
                                        : {data_in, shifter[7:1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          // CPHA=1 drives on the leading edge, CPHA=0 after the sample
          if (shift && !(cpha == 1'b0 && bit_cnt == 4'h0 && !sample))
            out_bit <= next_out;
          if (last_bit) state <= USM_DONE;
          if (!master && !slave_sel) state <= USM_IDLE;
        end
        USM_DONE: begin
          // Wait for the final trailing edge in master so SCK returns idle
          if (!master || m_trail || cpha) begin
            state    <= USM_IDLE;
            sck_lvl  <= 1'b0;
            ss_drive <= 1'b1;
          end
          if (master && !cpha)
            div_cnt <= (div_cnt == 8'h00) ? divider : div_cnt - 8'h01;
        end
      endcase
    end
  end

  // ==========================================================================
  // Buffers and flags; a new byte wins over a simultaneous read
  wire xfer_end = last_bit;
  always_ff @(posedge mclk) begin
    if (sys_rst || soft_rst || !unit_enable) begin
      tx_buffer_empty_flag    <= 1'b1;
      tx_done_flag    <= 1'b0;
      rx_pending_flag    <= 1'b0;
      dor    <= 1'b0;
      tx_buf <= 8'h00;
      rx_buf <= 8'h00;
      rxc_9  <= 1'b0;
      wake   <= 1'b0;
    end else begin
      if (data_wr) begin
        tx_buf <= reg_wdata;
        tx_buffer_empty_flag    <= 1'b0;
        tx_done_flag    <= 1'b0;
      end else if (active && state == USM_IDLE && start_ok)
        tx_buffer_empty_flag <= 1'b1;
      if (xfer_end && tx_buffer_empty_flag && !data_wr) tx_done_flag <= 1'b1;
      else if (reg_wr && sel_st && !reg_wdata[USM_ST_TXC]) tx_done_flag <= 1'b0;
      if (xfer_end && receiver_on) begin
        rx_buf <= first_bit_select ? {shifter[6:0], data_in}
                                   : {data_in, shifter[7:1]};
        rx_pending_flag    <= 1'b1;
        dor    <= rx_pending_flag & ~data_rd;
      end else if (data_rd) begin
        rx_pending_flag <= 1'b0;
        dor <= 1'b0;
      end
      if (!receiver_on) rx_pending_flag <= 1'b0;
      // Wake only in asynchronous mode, on a low receive pin during stop
      if (stop_mode && !s_rxd && !spi_mode && op_mode_field == USM_MODE_ASYNC)
        wake <= 1'b1;
      else if (reg_wr && sel_st && !reg_wdata[USM_ST_WAKE]) wake <= 1'b0;
      rxc_9 <= 1'b0;
    end
  end

  // ==========================================================================
  // Read mux and interrupt
  wire [7:0] status = {tx_buffer_empty_flag, tx_done_flag, rx_pending_flag, wake, 1'b0, dor, 2'b00};
  wire [7:0] c3_rd  = {ctrl3[7:1], rxc_9};
  always_ff @(posedge mclk) begin
    if (sys_rst) reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= sel_c1 ? ctrl1 : sel_c2 ? ctrl2 : sel_c3 ? c3_rd :
                   sel_st ? status : sel_dv ? divider : sel_dr ? rx_buf : 8'h00;
  end

  assign irq = (tx_buffer_empty_flag & ctrl2[USM_C2_TX_EMPTY_IRQ_ENABLE]) | (tx_done_flag & ctrl2[USM_C2_TX_DONE_IRQ_ENABLE])
             | (rx_pending_flag & ctrl2[USM_C2_RX_PENDING_IRQ_ENABLE]) | (wake & ctrl2[USM_C2_WAKIE]);

  // ==========================================================================
  // Pin drivers; master drives MOSI, slave drives MISO while selected
  wire drive_data = active & (master | slave_sel) & ~loopback_select;
  wire free_sck   = master & ~sck_gating_select & ~spi_mode & unit_enable;
  assign sck_out  = cpol ^ sck_lvl;
  assign sck_oe   = active & master;
  assign ss_n_out = ss_drive;
  assign ss_n_oe  = active & master & ~slave_select_control;
  assign txd_out  = out_bit;
  assign rxd_out  = out_bit;
  assign txd_oe   = drive_data & (master ^ pin_swap_select);
  assign rxd_oe   = drive_data & ~(master ^ pin_swap_select) & ~free_sck;

  // ==========================================================================
  // Checks
  AST_DRE_RESET: assert property (@(posedge mclk) $fell(sys_rst) |-> tx_buffer_empty_flag)
    else $error("transmit empty flag not one after reset");
  AST_START: assert property (@(posedge mclk) disable iff (sys_rst)
    data_wr |=> !tx_buffer_empty_flag) else $error("write did not fill buffer");
  AST_SPI_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
    !spi_mode |-> !sck_oe) else $error("sck driven outside spi");
  AST_RXC: assert property (@(posedge mclk) disable iff (sys_rst)
    (last_bit && receiver_on && !soft_rst) |=> rx_pending_flag) else $error("rxc not set");
  AST_RDCLR: assert property (@(posedge mclk) disable iff (sys_rst)
    (data_rd && !last_bit && unit_enable) |=> !rx_pending_flag) else $error("rxc not cleared");
  AST_SS: assert property (@(posedge mclk) disable iff (sys_rst)
    (active && !master) |-> !ss_n_oe) else $error("slave drives select");
  AST_SWAP: assert property (@(posedge mclk) disable iff (sys_rst)
    (txd_oe && rxd_oe) |-> 0) else $error("both data pins driven");
  AST_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
    (tx_buffer_empty_flag && ctrl2[USM_C2_TX_EMPTY_IRQ_ENABLE]) |-> irq) else $error("irq missing");
  // Master clock must rest at its polarity level whenever select is released
  AST_SCK_IDLE: assert property (@(posedge mclk) disable iff (sys_rst)
    (sck_oe && ss_n_oe && ss_n_out) |-> (sck_out == cpol))
    else $error("master clock not at idle level");
  AST_SLV_WAIT: assert property (@(posedge mclk) disable iff (sys_rst)
    (active && !master && !cpha && state == USM_IDLE && !ss_fall) |=> (state == USM_IDLE))
    else $error("slave started without select fall");
endmodule

// file: dv/usm_spi_peer.sv
/*
  Far-side SPI model: acts as slave while the unit masters, as master otherwise.
  Assumes the bench resolves every pin level from the unit's output enables.
*/
`timescale 1ns/10ps
module usm_spi_peer (
  input  wire logic sck,
  input  wire logic ss_n,
  input  wire logic din,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic msb,
  input  wire logic as_master,
  output logic      sck_drv,
  output logic      ss_drv,
  output logic      dout
);
  logic [7:0] tx_byte;
  logic [7:0] got;
  int         cnt;

  // Bit position of the i-th bit on the wire
  function automatic int idx(input int i);
    return msb ? 7 - i : i;
  endfunction

  // Idle levels; data idles high so no stray start bit is seen
  initial begin
    sck_drv = 1'b0;
    ss_drv  = 1'b1;
    dout    = 1'b1;
    tx_byte = 8'h00;
    got     = 8'h00;
    cnt     = 0;
  end

  // ==========================================================================
  // Slave role
  // Frame start: first bit at once for CPHA=0, junk until first edge otherwise
  always @(negedge ss_n) begin
    if (!as_master) begin
      cnt  = 0;
      dout = cpha ? ~dout : tx_byte[idx(0)];
    end
  end

  // Released line shows the inverse of its last bit
  always @(posedge ss_n) begin
    if (!as_master) dout = ~dout;
  end

  // Odd edges sample for CPHA=0, even edges for CPHA=1
  always @(sck) begin
    if (!as_master && ss_n === 1'b0 && cnt < 16) begin
      cnt = cnt + 1;
      if (cnt[0] != cpha) got[idx((cnt - 1) / 2)] = din;
      else if (cpha) dout = tx_byte[idx((cnt - 1) / 2)];
      else if (cnt < 16) dout = tx_byte[idx(cnt / 2)];
    end
  end

  // ==========================================================================
  // Master role: 80 ns clock, stands still outside frames
  task automatic run_master(input logic [7:0] tx, input bit hold);
    int i;
    sck_drv = cpol;
    ss_drv  = 1'b0;
    if (!cpha) dout = tx[idx(0)];
    #100;
    for (i = 0; i < 8; i++) begin
      sck_drv = ~sck_drv;
      if (cpha) dout = tx[idx(i)];
      else got[idx(i)] = din;
      #40;
      sck_drv = ~sck_drv;
      if (cpha) got[idx(i)] = din;
      else if (i < 7) dout = tx[idx(i + 1)];
      #40;
    end
    // Select may stay low between CPHA=1 transfers only
    if (!hold) begin
      ss_drv = 1'b1;
      dout   = ~dout;
    end
    #100;
  endtask
endmodule

// file: dv/tb.sv
/*
  Self-checking bench for the serial unit in SPI mode.
  Assumes the peer model on the far pins and a 100 MHz system clock.
*/
`timescale 1ns/10ps
module tb import usm_pkg::*;;
  logic        mclk, sys_rst, reg_wr, reg_rd, stop_mode;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, r, v;
  logic        irq, sck_out, sck_oe, ss_n_out, ss_n_oe, rxd_out, rxd_oe, txd_out, txd_oe;
  logic        p_sck, p_ss, p_out, p_cpol, p_cpha, p_msb, p_master;
  int          n_errors, checks, i;
  logic [7:0]  rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'hff, 8'h00, 8'h00};
  // Pin levels resolved from the output enables
  wire sck_w = sck_oe ? sck_out : p_sck;
  wire ss_w  = ss_n_oe ? ss_n_out : p_ss;
  wire d_out = txd_oe ? txd_out : rxd_out;
  wire rxd_w = rxd_oe ? rxd_out : p_out;
  wire txd_w = txd_oe ? txd_out : p_out;

  usm_core u_dut (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .stop_mode, .irq, .sck_in(sck_w), .sck_out, .sck_oe, .ss_n_in(ss_w), .ss_n_out,
    .ss_n_oe, .rxd_in(rxd_w), .rxd_out, .rxd_oe, .txd_in(txd_w), .txd_out, .txd_oe);
  usm_spi_peer u_peer (.sck(sck_w), .ss_n(ss_w), .din(d_out), .cpol(p_cpol),
    .cpha(p_cpha), .msb(p_msb), .as_master(p_master), .sck_drv(p_sck),
    .ss_drv(p_ss), .dout(p_out));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end

  // ==========================================================================
  // Shared tasks; requests change at the falling edge
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
  // Poll the receive flag under a bounded count
  task automatic wait_rxc();
    logic [7:0] s;
    int         n;
    s = 8'h00;
    for (n = 0; n < 300 && s[USM_ST_RXC] !== 1'b1; n++) rd(USM_OFF_STATUS, s);
    chk(8'(s[USM_ST_RXC]), 8'h01);
  endtask
  task automatic set_mode(input logic [1:0] m, input logic msb, input logic mst);
    p_cpol   = m[1];
    p_cpha   = m[0];
    p_msb    = msb;
    p_master = ~mst;
    wr(USM_OFF_CTRL1, {USM_MODE_SPI, 3'b000, msb, m[0], m[1]});
  endtask
  // Unit as master against the peer slave
  task automatic master_case(input logic [1:0] m, input logic msb, input logic swap);
    logic [7:0] tx, px;
    tx = 8'($urandom);
    px = 8'($urandom);
    u_peer.tx_byte = px;
    wr(USM_OFF_DIV, 8'($urandom_range(2, 6)));
    wr(USM_OFF_CTRL3, {1'b1, 3'b000, swap, 3'b000});
    set_mode(m, msb, 1'b1);
    wr(USM_OFF_DATA, tx);
    repeat (4) @(negedge mclk);
    chk({6'h00, sck_oe, ss_n_oe}, 8'h03);
    wait_rxc();
    chk(u_peer.got, tx);
    rd(USM_OFF_DATA, r);
    chk(r, px);
    rd(USM_OFF_STATUS, r);
    chk(r, 8'hc0);
  endtask
  // Unit as slave; second byte waits in the buffer, CPHA=1 keeps select low
  task automatic slave_case(input logic [1:0] m, input logic msb);
    logic [7:0] a, b, pa, pb;
    a  = 8'($urandom);
    b  = 8'($urandom);
    pa = 8'($urandom);
    pb = 8'($urandom);
    wr(USM_OFF_CTRL3, 8'h10);
    set_mode(m, msb, 1'b0);
    wr(USM_OFF_DATA, a);
    repeat (8) @(negedge mclk);
    rd(USM_OFF_STATUS, r);
    chk(r, 8'h00);
    chk({6'h00, sck_oe, ss_n_oe}, 8'h00);
    // Second byte goes in once the first has left the buffer mid-frame
    fork
      u_peer.run_master(pa, m[0]);
      begin
        repeat (20) @(negedge mclk);
        wr(USM_OFF_DATA, b);
      end
    join
    chk(u_peer.got, a);
    rd(USM_OFF_DATA, r);
    chk(r, pa);
    u_peer.run_master(pb, 1'b0);
    chk(u_peer.got, b);
    rd(USM_OFF_DATA, r);
    chk(r, pb);
  endtask
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, stop_mode} = 4'b1000;
    reg_addr  = 16'h0000;
    reg_wdata = 8'h00;
    {p_cpol, p_cpha, p_msb, p_master} = 4'b0000;
    void'($urandom(99796));
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    // Reset values, unmapped address last
    for (i = 0; i < 7; i++) begin
      rd(USM_OFF_CTRL1 + 16'(i), r);
      chk(r, rst_tab[i]);
    end
    // Stored fields read back
    for (i = 0; i < 3; i++) begin
      v = (i == 2) ? 8'($urandom_range(2, 255)) : 8'($urandom);
      wr((i == 2) ? USM_OFF_DIV : USM_OFF_CTRL1 + 16'(i), v);
      rd((i == 2) ? USM_OFF_DIV : USM_OFF_CTRL1 + 16'(i), r);
      chk(r, v);
    end
    wr(USM_OFF_CTRL1, 8'h00);
    wr(USM_OFF_CTRL2, 8'h80);
    chk(8'(irq), 8'h01);
    wr(USM_OFF_CTRL2, 8'h00);
    chk(8'(irq), 8'h00);
    // Data writes outside SPI mode or with the unit off start nothing
    wr(USM_OFF_DIV, 8'h02);
    wr(USM_OFF_CTRL3, 8'h80);
    for (i = 0; i < 4; i++) begin
      wr(USM_OFF_CTRL1, {2'(i), 6'h00});
      wr(USM_OFF_CTRL2, (i == 3) ? 8'h00 : 8'h0a);
      wr(USM_OFF_DATA, 8'($urandom));
      repeat (60) @(negedge mclk);
      rd(USM_OFF_STATUS, r);
      chk(r, 8'h80);
    end
    wr(USM_OFF_CTRL2, 8'h0e);
    for (i = 0; i < 8; i++) master_case(2'(i >> 1), i[0], i[1] ^ i[2]);
    // Loopback: data pins released, clock and select still driven, own byte comes back
    wr(USM_OFF_CTRL3, 8'hc0);
    v = 8'($urandom);
    wr(USM_OFF_DATA, v);
    repeat (6) @(negedge mclk);
    chk({6'h00, txd_oe, rxd_oe}, 8'h00);
    wait_rxc();
    rd(USM_OFF_DATA, r);
    chk(r, v);
    for (i = 0; i < 4; i++) slave_case(2'(i), 1'($urandom));
    stop_test();
  end
endmodule
